// file: core/egp_pkg.sv
package egp_pkg;
   localparam int EGP_W = 8;
   localparam int EGP_SYNC_STAGES = 2;
   // byte offsets inside the 4 kB window
   localparam logic [11:0] EGP_DATA_BASE = 12'h000;
   localparam logic [11:0] EGP_DATA_LAST = 12'h3fc;
   localparam logic [11:0] EGP_DIR_OFS = 12'h400;
   localparam logic [11:0] EGP_SENSE_OFS = 12'h404;
   localparam logic [11:0] EGP_BOTH_OFS = 12'h408;
   localparam logic [11:0] EGP_POL_OFS = 12'h40c;
   localparam logic [11:0] EGP_MASK_OFS = 12'h410;
   localparam logic [11:0] EGP_RAW_OFS = 12'h414;
   localparam logic [11:0] EGP_MIS_OFS = 12'h418;
   localparam logic [11:0] EGP_CLR_OFS = 12'h41c;
   localparam logic [11:0] EGP_MODE_OFS = 12'h420;
   localparam logic [11:0] EGP_ID_BASE = 12'hfe0;
   localparam logic [7:0] EGP_RESET_VAL = 8'h00;
   // identification bytes, values arbitrary
   localparam logic [7:0] EGP_ID_BYTES [8] = '{8'h5a, 8'h10, 8'h20, 8'h01,
                                                8'h0d, 8'hf0, 8'h05, 8'hb1};
   typedef struct packed {
      logic [7:0] sense;    // 1 = level, 0 = edge
      logic [7:0] both;     // 1 = both edges
      logic [7:0] pol;      // 1 = rising / high
      logic [7:0] mask;     // 1 = enabled
   } egp_irq_cfg_t;
endpackage : egp_pkg

// file: core/egp_sync.sv
`timescale 1ns/100ps
`default_nettype none
module egp_sync
   import egp_pkg::*;
(
   input wire logic sys_clk_i,              // clock
   input wire logic rstn_i,                 // sync reset, low
   input wire logic [EGP_W-1:0] async_i,    // pad levels
   output logic [EGP_W-1:0] sync_o          // synchronised levels
);
   logic [EGP_W-1:0] s1_q, s1_d, s2_q, s2_d;

   always_comb
   begin
      s1_d = async_i;
      s2_d = s1_q;
   end

   genvar g;
   generate
      for (g = 0; g < EGP_W; g++)
      begin : g_bit
         always_ff @(posedge sys_clk_i)
         begin
            if (!rstn_i)
            begin
               s1_q[g] <= 1'b0;
               s2_q[g] <= 1'b0;
            end
            else
            begin
               s1_q[g] <= s1_d[g];
               s2_q[g] <= s2_d[g];
            end
         end
      end
   endgenerate

   assign sync_o = s2_q;
endmodule : egp_sync
`default_nettype wire

// file: core/egp_irq_detect.sv
`timescale 1ns/100ps
`default_nettype none
module egp_irq_detect
   import egp_pkg::*;
(
   input wire logic sys_clk_i,              // clock
   input wire logic rstn_i,                 // sync reset, low
   input wire logic [EGP_W-1:0] level_i,    // synchronised pins
   input wire egp_irq_cfg_t cfg_i,          // trigger setup
   input wire logic [EGP_W-1:0] clear_i,    // clear pulse per line
   output logic [EGP_W-1:0] raw_o           // raw status
);
   logic [EGP_W-1:0] prev_q, prev_d, latch_q, latch_d, raw_d;

   genvar g;
   generate
      for (g = 0; g < EGP_W; g++)
      begin : g_line
         logic rise, fall, edge_hit;
         always_comb
         begin
            rise = level_i[g] & ~prev_q[g];
            fall = ~level_i[g] & prev_q[g];
            edge_hit = cfg_i.both[g] ? (rise | fall)
                                     : (cfg_i.pol[g] ? rise : fall);
            latch_d[g] = edge_hit | (latch_q[g] & ~clear_i[g]);
            raw_d[g] = cfg_i.sense[g] ? (level_i[g] == cfg_i.pol[g])
                                      : latch_d[g];
         end
      end
   endgenerate

   always_comb
   begin
      prev_d = level_i;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!rstn_i)
      begin
         prev_q <= EGP_RESET_VAL;
         latch_q <= EGP_RESET_VAL;
         raw_o <= EGP_RESET_VAL;
      end
      else
      begin
         prev_q <= prev_d;
         latch_q <= latch_d;
         raw_o <= raw_d;
      end
   end
endmodule : egp_irq_detect
`default_nettype wire

// file: core/egp_gpio.sv
// What this block does
// - eight-bit direction register, one bit per pin
// - data reads inputs, writes drive outputs
// - data aliased; address bits 9:2 mask
// - data read returns levels of addressed pins, zero elsewhere
// - data write updates every addressed bit, input pins included
// - seven interrupt registers, one bit per line
// - level, single edge or both edges
// - raw, masked, enable, write-only clear
// - masked interrupt output per line
// - mask one enables, zero blocks
// - combined irq is OR of masked
// - per-line mode select, software default
// - software mode: direction register drives enable
// - hardware mode: auxiliary port drives line
// - pins readable in hardware mode
// - reset clears registers, pins inputs
// - reset: irqs off, raw zero, edge
// - read/write decodes; identification read-only
// - masked write changes only addressed bits
`timescale 1ns/100ps
`default_nettype none
module egp_gpio
   import egp_pkg::*;
(
   input wire logic sys_clk_i,                   // clock, 20 MHz
   input wire logic rstn_i,                      // sync reset, low
   input wire logic psel,                        // apb select
   input wire logic penable,                     // apb access phase
   input wire logic pwrite,                      // apb write
   input wire logic [11:0] paddr,                // apb byte address
   input wire logic [31:0] pwdata,               // apb write data
   output logic [31:0] prdata,                   // apb read data
   input wire logic [EGP_W-1:0] pin_inputs,      // pad input levels
   output logic [EGP_W-1:0] pad_out_o,           // pad output data
   output logic [EGP_W-1:0] pad_oe_o,            // pad output enable
   input wire logic [EGP_W-1:0] aux_out_i,       // aux output data
   input wire logic [EGP_W-1:0] aux_oe_i,        // aux output enable
   output logic [EGP_W-1:0] aux_in_o,            // pin level to aux
   output logic [EGP_W-1:0] line_irq_o,          // masked irq per line
   output logic combined_irq_out                 // any masked irq
);
   logic [EGP_W-1:0] pin_direction_q, pin_direction_d;
   logic [EGP_W-1:0] pin_data_q, pin_data_d;
   logic [EGP_W-1:0] line_mode_select_q, line_mode_select_d;
   egp_irq_cfg_t cfg_q, cfg_d;
   logic [EGP_W-1:0] irq_clear;
   logic [31:0] prdata_d;
   logic [EGP_W-1:0] pad_out_d, pad_oe_d, aux_in_d, line_irq_d;
   logic combined_d;
   logic [EGP_W-1:0] pin_level, raw_irq, mis;
   logic wr_en, rd_setup, in_data;
   logic [EGP_W-1:0] addr_mask;
   logic [7:0] wbyte;

   egp_sync u_sync (
      .sys_clk_i (sys_clk_i),
      .rstn_i (rstn_i),
      .async_i (pin_inputs),
      .sync_o (pin_level)
   );

   egp_irq_detect u_irq (
      .sys_clk_i (sys_clk_i),
      .rstn_i (rstn_i),
      .level_i (pin_level),
      .cfg_i (cfg_q),
      .clear_i (irq_clear),
      .raw_o (raw_irq)
   );

   // decode helpers
   always_comb
   begin
      wr_en = psel & penable & pwrite;
      // read data is fetched in setup so it comes from a flop
      rd_setup = psel & ~penable & ~pwrite;
      in_data = (paddr >= EGP_DATA_BASE) && (paddr <= EGP_DATA_LAST);
      addr_mask = paddr[9:2];
      wbyte = pwdata[7:0];
   end

   always_comb
   begin
      mis = raw_irq & cfg_q.mask;
   end

   // register writes
   always_comb
   begin
      pin_direction_d = pin_direction_q;
      pin_data_d = pin_data_q;
      line_mode_select_d = line_mode_select_q;
      cfg_d = cfg_q;
      irq_clear = '0;
      if (wr_en)
      begin
         if (in_data)
         begin
            pin_data_d = (pin_data_q & ~addr_mask) | (wbyte & addr_mask);
         end
         else
         begin
            case (paddr)
               EGP_DIR_OFS: pin_direction_d = wbyte;
               EGP_SENSE_OFS: cfg_d.sense = wbyte;
               EGP_BOTH_OFS: cfg_d.both = wbyte;
               EGP_POL_OFS: cfg_d.pol = wbyte;
               EGP_MASK_OFS: cfg_d.mask = wbyte;
               EGP_CLR_OFS: irq_clear = wbyte;
               EGP_MODE_OFS: line_mode_select_d = wbyte;
               // id space and status ignore writes
               default: ;
            endcase
         end
      end
   end

   // read mux
   always_comb
   begin
      prdata_d = prdata;
      if (rd_setup)
      begin
         prdata_d = '0;
         if (in_data)
         begin
            prdata_d[7:0] = pin_level & addr_mask;
         end
         else if (paddr >= EGP_ID_BASE)
         begin
            prdata_d[7:0] = EGP_ID_BYTES[paddr[4:2]];
         end
         else
         begin
            case (paddr)
               EGP_DIR_OFS: prdata_d[7:0] = pin_direction_q;
               EGP_SENSE_OFS: prdata_d[7:0] = cfg_q.sense;
               EGP_BOTH_OFS: prdata_d[7:0] = cfg_q.both;
               EGP_POL_OFS: prdata_d[7:0] = cfg_q.pol;
               EGP_MASK_OFS: prdata_d[7:0] = cfg_q.mask;
               EGP_RAW_OFS: prdata_d[7:0] = raw_irq;
               EGP_MIS_OFS: prdata_d[7:0] = mis;
               EGP_MODE_OFS: prdata_d[7:0] = line_mode_select_q;
               // clear register is write-only, unmapped reads zero
               default: prdata_d = '0;
            endcase
         end
      end
   end

   // pad and aux muxing
   always_comb
   begin
      pad_out_d = (line_mode_select_q & aux_out_i)
                | (~line_mode_select_q & pin_data_q);
      pad_oe_d = (line_mode_select_q & aux_oe_i)
               | (~line_mode_select_q & pin_direction_q);
      aux_in_d = pin_level & line_mode_select_q;
      line_irq_d = mis;
      combined_d = |mis;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!rstn_i)
      begin
         pin_direction_q <= EGP_RESET_VAL;
         pin_data_q <= EGP_RESET_VAL;
         line_mode_select_q <= EGP_RESET_VAL;
         cfg_q <= '0;
         prdata <= '0;
         pad_out_o <= EGP_RESET_VAL;
         pad_oe_o <= EGP_RESET_VAL;
         aux_in_o <= EGP_RESET_VAL;
         line_irq_o <= EGP_RESET_VAL;
         combined_irq_out <= 1'b0;
      end
      else
      begin
         pin_direction_q <= pin_direction_d;
         pin_data_q <= pin_data_d;
         line_mode_select_q <= line_mode_select_d;
         cfg_q <= cfg_d;
         prdata <= prdata_d;
         pad_out_o <= pad_out_d;
         pad_oe_o <= pad_oe_d;
         aux_in_o <= aux_in_d;
         line_irq_o <= line_irq_d;
         combined_irq_out <= combined_d;
      end
   end
endmodule : egp_gpio
`default_nettype wire

// file: tb/egp_pad.sv
`timescale 1ns/100ps
`default_nettype none
module egp_pad
   import egp_pkg::*;
(
   input wire logic [EGP_W-1:0] pad_out_i, // data from block
   input wire logic [EGP_W-1:0] pad_oe_i,  // enable from block
   input wire logic [EGP_W-1:0] ext_val_i, // board level
   input wire logic [EGP_W-1:0] ext_en_i,  // board drives
   output logic [EGP_W-1:0] pin_o          // pad level
);
   // undriven pads sit on a weak pull-down; the block wins contention
   assign pin_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_en_i & ext_val_i);
endmodule : egp_pad
`default_nettype wire

// file: tb/egp_gpio_chk.sv
`timescale 1ns/100ps
`default_nettype none
module egp_gpio_chk
   import egp_pkg::*;
(
   input wire logic sys_clk_i,              // clock
   input wire logic rstn_i,                 // reset, low
   input wire logic psel,                   // select
   input wire logic penable,                // access
   input wire logic pwrite,                 // write
   input wire logic [11:0] paddr,           // address
   input wire logic [31:0] pwdata,          // write data
   input wire logic [31:0] prdata,          // read data
   input wire logic [EGP_W-1:0] pin_inputs, // pins
   input wire logic [EGP_W-1:0] pad_out_o,  // pad data
   input wire logic [EGP_W-1:0] pad_oe_o,   // pad enable
   input wire logic [EGP_W-1:0] aux_out_i,  // aux data
   input wire logic [EGP_W-1:0] aux_oe_i,   // aux enable
   input wire logic [EGP_W-1:0] line_irq_o, // line irqs
   input wire logic combined_irq_out        // any irq
);
   logic wr, rd;
   logic [7:0] mode_q, mask_q;
   assign wr = psel & penable & pwrite;
   assign rd = psel & !penable & !pwrite;
   always_ff @(posedge sys_clk_i)
   begin
      if (!rstn_i)
      begin
         mode_q <= '0;
         mask_q <= '0;
      end
      else if (wr && paddr == EGP_MODE_OFS)
         mode_q <= pwdata[7:0];
      else if (wr && paddr == EGP_MASK_OFS)
         mask_q <= pwdata[7:0];
   end
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rstn_i);
   property p_comb; combined_irq_out == (|line_irq_o); endproperty
   a_comb: assert property (p_comb)
      else $error("combined irq differs from line irqs");
   property p_rst;
      $rose(rstn_i) |-> pad_oe_o == '0 && pad_out_o == '0 && line_irq_o == '0;
   endproperty
   a_rst: assert property (p_rst)
      else $error("outputs not cleared by reset");
   property p_oe;
      wr && paddr == EGP_DIR_OFS |->
         ##2 (pad_oe_o & ~mode_q) == ($past(pwdata[7:0], 2) & ~mode_q);
   endproperty
   a_oe: assert property (p_oe)
      else $error("pad enable does not follow direction");
   // mux flop samples the mode held before the edge
   property p_aux;
      (pad_oe_o & $past(mode_q)) == ($past(aux_oe_i) & $past(mode_q)) &&
      (pad_out_o & $past(mode_q)) == ($past(aux_out_i) & $past(mode_q));
   endproperty
   a_aux: assert property (p_aux)
      else $error("hardware lines not driven by aux port");
   property p_mask; (line_irq_o & ~$past(mask_q)) == '0; endproperty
   a_mask: assert property (p_mask)
      else $error("masked line raised an irq");
   property p_id;
      rd && paddr[11:5] == 7'h7f |=>
         prdata == {24'h0, EGP_ID_BYTES[$past(paddr[4:2])]};
   endproperty
   a_id: assert property (p_id)
      else $error("identification read wrong");
   property p_data;
      rd && paddr[11:10] == 2'b00 && $past(rstn_i, 2) |=>
         prdata == {24'h0, $past(pin_inputs, 3) & $past(paddr[9:2])};
   endproperty
   a_data: assert property (p_data)
      else $error("data read not masked pin level");
   property p_clr; rd && paddr == EGP_CLR_OFS |=> prdata == '0; endproperty
   a_clr: assert property (p_clr)
      else $error("clear register readable");
   c_irq: cover property (combined_irq_out);
   c_aux: cover property (|(pad_oe_o & mode_q));
   c_id: cover property (rd && paddr == EGP_ID_BASE);
endmodule : egp_gpio_chk
bind egp_gpio egp_gpio_chk u_chk (.*);
`default_nettype wire

// file: tb/test_eight_bit_gpio_port.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) \
   compares++; \
   if ((g) !== (e)) \
   begin \
      failures++; \
      $display("unexpected %s expected %h seen %h", n, e, g); \
   end
module test_eight_bit_gpio_port;
   import egp_pkg::*;
   logic sys_clk_i = 0, rstn_i = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic [7:0] pins, pad_out, pad_oe, aux_out = '0, aux_oe = '0, aux_in;
   logic [7:0] line_irq, ext_val = '0, ext_en = '0, rv;
   logic comb;
   int failures = 0, compares = 0;
   always #25 sys_clk_i = ~sys_clk_i;
   egp_gpio dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pin_inputs(pins), .pad_out_o(pad_out),
      .pad_oe_o(pad_oe), .aux_out_i(aux_out), .aux_oe_i(aux_oe),
      .aux_in_o(aux_in), .line_irq_o(line_irq), .combined_irq_out(comb));
   egp_pad u_pad (.pad_out_i(pad_out), .pad_oe_i(pad_oe), .ext_val_i(ext_val),
      .ext_en_i(ext_en), .pin_o(pins));
   task automatic idle(input int n);
      repeat (n) @(negedge sys_clk_i);
   endtask : idle
   task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(negedge sys_clk_i);
      psel = 1;
      pwrite = w;
      paddr = a;
      pwdata = {24'h0, d};
      @(negedge sys_clk_i);
      penable = 1;
      @(negedge sys_clk_i);
      rv = prdata[7:0];
      psel = 0;
      penable = 0;
   endtask : bus
   task automatic rdc(input string n, input logic [11:0] a, input logic [7:0] e);
      bus(0, a, 8'h00);
      `CHK(n, e, rv)
   endtask : rdc
   task automatic t_reset;
      for (int i = 0; i < 9; i++) rdc("cfg", EGP_DIR_OFS + 12'(4 * i), 8'h00);
      `CHK("oe", 8'h00, pad_oe)
      $display("test reset done");
   endtask : t_reset
   task automatic t_data;
      ext_en = 8'h0f;
      ext_val = 8'h0a;
      bus(1, EGP_DIR_OFS, 8'hf0);
      bus(1, 12'h3fc, 8'hff);
      idle(4);
      rdc("pins", 12'h3fc, 8'hfa);
      bus(1, 12'h098, 8'h00);
      idle(4);
      `CHK("pad_out", 8'hd9, pad_out)
      rdc("masked", 12'h0c4, 8'h10);
      $display("test data done");
   endtask : t_data
   task automatic t_irq;
      bus(1, EGP_BOTH_OFS, 8'h00);
      bus(1, EGP_POL_OFS, 8'h01);
      bus(1, EGP_SENSE_OFS, 8'h02);
      idle(3);
      bus(1, EGP_CLR_OFS, 8'hff);
      bus(1, EGP_MASK_OFS, 8'h07);
      ext_val = 8'h0b;
      idle(6);
      `CHK("edge", 8'h01, line_irq)
      `CHK("comb", 1'b1, comb)
      bus(1, EGP_CLR_OFS, 8'h01);
      idle(3);
      rdc("raw", EGP_RAW_OFS, 8'h00);
      ext_val = 8'h09;
      idle(6);
      `CHK("level", 8'h02, line_irq)
      bus(1, EGP_MASK_OFS, 8'h05);
      idle(3);
      rdc("mis", EGP_MIS_OFS, 8'h00);
      bus(1, EGP_BOTH_OFS, 8'h04);
      ext_val = 8'h0d;
      idle(6);
      bus(1, EGP_CLR_OFS, 8'h04);
      ext_val = 8'h09;
      idle(6);
      rdc("both", EGP_RAW_OFS, 8'h06);
      $display("test irq done");
   endtask : t_irq
   task automatic t_aux;
      aux_oe = 8'h0c;
      aux_out = 8'h04;
      ext_en = 8'h03;
      bus(1, EGP_MODE_OFS, 8'h0c);
      idle(5);
      `CHK("aux_oe", 8'hfc, pad_oe)
      `CHK("aux_out", 8'hd5, pad_out)
      `CHK("aux_in", 8'h04, aux_in)
      rdc("hw pins", 12'h3fc, 8'hd5);
      rdc("dir", EGP_DIR_OFS, 8'hf0);
      rdc("id", EGP_ID_BASE, EGP_ID_BYTES[0]);
      rdc("unmapped", 12'h800, 8'h00);
      $display("test aux done");
   endtask : t_aux
   task automatic final_report;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : final_report
   initial
   begin
      idle(2);
      rstn_i = 1;
      t_reset;
      t_data;
      t_irq;
      t_aux;
      final_report;
   end
   initial
   begin
      #100us;
      failures++;
      final_report;
   end
endmodule : test_eight_bit_gpio_port
`default_nettype wire
